// File: rtl/rsc_pkg.sv
// Purpose: shared constants for the reset source controller
// Assumes: 32-bit apb register words, mclk at 250 MHz
// Notes: flags follow the active-low cause convention unless named stack_*
package rsc_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned START_DELAY_CYCLES = 10;
  localparam logic [3:0] START_DELAY_LOAD = 4'(START_DELAY_CYCLES - 1);
  localparam int unsigned POWERUP_TIMER_TIME_MS = 64;
  localparam int unsigned POWERUP_TIMER_CYCLES = POWERUP_TIMER_TIME_MS * 1000 * 1000 / 4;
  localparam int unsigned BOR_FILTER_TIME_NS = 1000;
  localparam int unsigned PIN_FILTER_TIME_NS = 200;
  // least times round up to whole cycles
  localparam int unsigned BOR_FILTER_CYCLES = (BOR_FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PIN_FILTER_CYCLES = (PIN_FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // brown-out modes
  localparam logic [1:0] BOR_MODE_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_MODE_AWAKE = 2'h2;
  localparam logic [1:0] BOR_MODE_SOFT = 2'h1;
  localparam logic [1:0] BOR_MODE_OFF = 2'h0;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] FLAGS_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam int unsigned CTRL_SOFT_BOR_BIT = 0;
  localparam int unsigned CTRL_PULLUP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // flags word: [0] brownout_cause [1] poweron_cause [2] reset_instr [3] ext_pin_reset
  // [4] watchdog_reset [5] powerdown [6] timeout [7] stack_under [8] stack_over
  localparam int unsigned FLAGS_WIDTH = 9;
  localparam logic [8:0] FLAGS_POWERON = 9'h07d;
  localparam logic [8:0] FLAGS_BROWNOUT_SET = 9'h06c;
  localparam logic [8:0] FLAGS_BROWNOUT_KEEP = 9'h012;
  localparam int unsigned FLAG_BOR = 0;
  localparam int unsigned FLAG_POR = 1;
  localparam int unsigned FLAG_RI = 2;
  localparam int unsigned FLAG_PIN = 3;
  localparam int unsigned FLAG_WDT = 4;
  localparam int unsigned FLAG_PD = 5;
  localparam int unsigned FLAG_TO = 6;
  localparam int unsigned FLAG_UNF = 7;
  localparam int unsigned FLAG_OVF = 8;

  // ==========================================================
  // start-up sequence states
  typedef enum logic [2:0] {
    RSC_SEQ_POWER = 3'b000,
    RSC_SEQ_POWERUP_TIMER = 3'b001,
    RSC_SEQ_GATE = 3'b010,
    RSC_SEQ_DELAY = 3'b011,
    RSC_SEQ_RUN = 3'b100
  } rsc_seq_t;
endpackage : rsc_pkg

// File: rtl/rsc_reset_source_controller.sv
// Purpose: merges reset sources into one core reset and records the cause
// Assumes: comparator and event inputs synchronous to mclk; config bits static
// Notes: apb slave answers with one wait state; writes land on the completing edge
// What this block does
// - leaving programming mode acts exactly like a power-on reset.
// - brown-out resets only after low supply outlasts the filter; clears its cause flag.
// - brown-out level select drives the comparator threshold select.
// - mode 11 always detects; start waits ready and good supply; wake not delayed.
// - mode 11 has detector ready before the core starts executing.
// - mode 10 detects while awake only; wake waits for detector ready.
// - mode 01 lets the soft enable bit switch detection on or off.
// - mode 01 start-up is not gated by ready or supply level.
// - software mode protects as soon as ready; ready flag shows detector state.
// - software mode protection does not change with sleep.
// - mode 00 keeps detection off, starts at once, ignores the soft enable.
// - pin reset enabled if low-voltage programming set, or pin enable set.
// - enabled pin held low keeps the device in reset.
// - pin reset path is filtered so short glitches are ignored.
// - a pin reset clears the pin reset flag.
// - internal resets never drive the reset pin; it stays input only.
// - pin function disabled means plain input with software pull-up.
// - watchdog overflow resets when awake, marking timeout and watchdog flags; in sleep it marks timeout and powerdown only.
// - reset instruction resets the device and clears its flag.
// - stack faults reset only if enabled, and set their matching flag.
// - optional power-up timer lengthens reset after power-on or brown-out.
// - execution starts ten clock cycles after the pin and timer release.
// - each reset marks its cause flag; power-on reloads all flags, brown-out all but the power-on and watchdog flags.
`timescale 1ns/1ps
module rsc_reset_source_controller
  import rsc_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_COUNT = POWERUP_TIMER_CYCLES,
  parameter int unsigned BOR_FILTER_COUNT = BOR_FILTER_CYCLES,
  parameter int unsigned PIN_FILTER_COUNT = PIN_FILTER_CYCLES
) (
  input wire logic mclk, // system clock
  input wire logic reset, // synchronous chip reset, active high
  input wire logic [1:0] brownout_mode_select, // configuration mode
  input wire logic [1:0] brownout_level_select, // configuration trip level
  input wire logic ext_reset_pin_enable, // configuration pin enable
  input wire logic low_voltage_prog_enable, // configuration low-voltage programming
  input wire logic powerup_timer_enable, // configuration timer enable
  input wire logic stack_reset_enable, // configuration stack reset enable
  input wire logic poweron_detect, // supply below power-on level
  input wire logic supply_below_threshold, // brown-out comparator
  input wire logic brownout_detector_ready, // detector warmed up
  input wire logic prog_mode_exit, // pulse: programming mode left
  input wire logic ext_reset_pin_in, // reset pin level
  input wire logic watchdog_overflow, // pulse: watchdog ran out uncleared
  input wire logic reset_instr, // pulse: reset instruction executed
  input wire logic stack_overflow, // pulse: stack overflow
  input wire logic stack_underflow, // pulse: stack underflow
  input wire logic sleep_active, // core is in sleep
  input wire logic wake_request, // pulse or level: wake event
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic core_reset, // merged core reset, active high
  output logic wake_allowed, // wake may proceed
  output logic brownout_detector_enable, // powers the detector
  output logic [1:0] brownout_threshold_select, // comparator threshold
  output logic ext_reset_pin_out, // pin output value
  output logic ext_reset_pin_oe, // pin output enable
  output logic ext_pin_pullup_enable, // weak pull-up on pin
  output logic ext_pin_gpio_in // pin value as general input
);

  // ==========================================================
  // state
  // one struct holds every register, so a single always_ff covers them all
  typedef struct packed {
    rsc_seq_t seq;
    logic [31:0] seq_cnt;
    logic [31:0] bor_cnt;
    logic [31:0] pin_cnt;
    logic pin_low; // filtered pin low
    logic [FLAGS_WIDTH-1:0] flags;
    logic [1:0] ctrl;
    logic [31:0] rdata;
    logic slverr;
    logic apb_ready; // wait state done, pready may rise
  } rsc_state_t;

  rsc_state_t cur;
  rsc_state_t next_cur;

  // apb decode shared by read and write paths
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == CTRL_OFFSET) || (a == FLAGS_OFFSET) || (a == STATUS_OFFSET);
  endfunction : addr_mapped

  logic bor_active;
  logic bor_protect;
  logic bor_trip;
  logic pin_func;
  logic power_event;
  logic start_gate_ok;
  logic apb_access;

  // ==========================================================
  // brown-out mode decode
  always_comb begin
    case (brownout_mode_select)
      BOR_MODE_ALWAYS: bor_active = 1'b1;
      BOR_MODE_AWAKE: bor_active = !sleep_active;
      BOR_MODE_SOFT: bor_active = cur.ctrl[CTRL_SOFT_BOR_BIT];
      BOR_MODE_OFF: bor_active = 1'b0;
      default: bor_active = 1'b0;
    endcase
  end

  assign bor_protect = bor_active && brownout_detector_ready;
  assign bor_trip = bor_protect && supply_below_threshold && (cur.bor_cnt >= BOR_FILTER_COUNT);
  assign pin_func = low_voltage_prog_enable || ext_reset_pin_enable;
  // programming exit is a power event
  assign power_event = poweron_detect || prog_mode_exit;

  // start-up gating on detector only for the hardware-forced modes
  always_comb begin
    case (brownout_mode_select)
      BOR_MODE_ALWAYS, BOR_MODE_AWAKE: start_gate_ok = brownout_detector_ready && !supply_below_threshold;
      default: start_gate_ok = 1'b1;
    endcase
  end

  assign apb_access = psel && penable;

  // ==========================================================
  // next state
  always_comb begin
    next_cur = cur;
    next_cur.slverr = 1'b0;

    // brown-out persistence counter, saturating
    // saturation keeps a long sag from wrapping the count and releasing the trip
    if (bor_protect && supply_below_threshold) begin
      if (cur.bor_cnt < BOR_FILTER_COUNT) begin
        next_cur.bor_cnt = cur.bor_cnt + 32'h1;
      end
    end else begin
      next_cur.bor_cnt = 32'h0;
    end

    // runs with the pin function off too, so enabling it never sees a stale level
    // glitch filter: level must hold for the filter count before it flips
    if (ext_reset_pin_in == !cur.pin_low) begin
      next_cur.pin_cnt = 32'h0;
    end else if (cur.pin_cnt + 32'h1 >= PIN_FILTER_COUNT) begin
      next_cur.pin_cnt = 32'h0;
      next_cur.pin_low = !ext_reset_pin_in;
    end else begin
      next_cur.pin_cnt = cur.pin_cnt + 32'h1;
    end

    // software register writes first, so hardware causes below win
    // a write lands on the edge that completes the transfer, when pready is high
    if (apb_access && pwrite && cur.apb_ready) begin
      case (paddr)
        CTRL_OFFSET: next_cur.ctrl = pwdata[1:0];
        FLAGS_OFFSET: next_cur.flags = pwdata[FLAGS_WIDTH-1:0];
        default: next_cur.ctrl = cur.ctrl;
      endcase
    end

    // read data captured in the access cycle
    if (apb_access && !pwrite) begin
      case (paddr)
        CTRL_OFFSET: next_cur.rdata = {30'h0, cur.ctrl};
        FLAGS_OFFSET: next_cur.rdata = {23'h0, cur.flags};
        STATUS_OFFSET: next_cur.rdata = {25'h0, cur.seq, cur.pin_low, bor_protect, core_reset,
                                         brownout_detector_ready};
        default: next_cur.rdata = 32'h0;
      endcase
    end
    if (apb_access) begin
      next_cur.slverr = !addr_mapped(paddr);
    end
    // one wait state: ready rises in the second access cycle and drops after it
    next_cur.apb_ready = apb_access && !cur.apb_ready;

    // ========================================================
    // reset sources, highest priority last
    // filtered pin low holds reset
    if (pin_func && cur.pin_low) begin
      next_cur.flags[FLAG_PIN] = 1'b0;
      if (sleep_active) begin
        next_cur.flags[FLAG_TO] = 1'b1;
        next_cur.flags[FLAG_PD] = 1'b0;
      end
      if (cur.seq == RSC_SEQ_RUN || cur.seq == RSC_SEQ_DELAY) begin
        next_cur.seq = RSC_SEQ_GATE;
      end
    end

    // watchdog: wake in sleep, reset when awake
    if (watchdog_overflow) begin
      next_cur.flags[FLAG_TO] = 1'b0;
      if (sleep_active) begin
        next_cur.flags[FLAG_PD] = 1'b0;
      end else begin
        next_cur.flags[FLAG_WDT] = 1'b0;
        next_cur.seq = RSC_SEQ_GATE;
      end
    end

    if (reset_instr) begin
      next_cur.flags[FLAG_RI] = 1'b0;
      next_cur.seq = RSC_SEQ_GATE;
    end

    if (stack_reset_enable && stack_overflow) begin
      next_cur.flags[FLAG_OVF] = 1'b1;
      next_cur.seq = RSC_SEQ_GATE;
    end
    if (stack_reset_enable && stack_underflow) begin
      next_cur.flags[FLAG_UNF] = 1'b1;
      next_cur.seq = RSC_SEQ_GATE;
    end

    if (bor_trip) begin
      next_cur.flags = (cur.flags & FLAGS_BROWNOUT_KEEP) | FLAGS_BROWNOUT_SET;
      next_cur.flags[FLAG_BOR] = 1'b0;
      next_cur.ctrl = CTRL_RESET;
      next_cur.seq = RSC_SEQ_POWER;
    end

    // last in line, so a power event overrides every other cause in the same cycle
    // power-on and programming exit
    if (power_event) begin
      next_cur.flags = FLAGS_POWERON;
      next_cur.ctrl = CTRL_RESET;
      next_cur.seq = RSC_SEQ_POWER;
    end

    // ========================================================
    // start-up sequence
    case (cur.seq)
      RSC_SEQ_POWER: begin
        // only the forced modes wait for a ready detector and good supply
        if (!power_event && !bor_trip && start_gate_ok) begin
          next_cur.seq = powerup_timer_enable ? RSC_SEQ_POWERUP_TIMER : RSC_SEQ_GATE;
          next_cur.seq_cnt = 32'h0;
        end
      end
      RSC_SEQ_POWERUP_TIMER: begin
        // timer runs regardless of the pin
        if (!power_event && !bor_trip) begin
          if (cur.seq_cnt + 32'h1 >= POWERUP_TIMER_COUNT) begin
            next_cur.seq = RSC_SEQ_GATE;
          end else begin
            next_cur.seq_cnt = cur.seq_cnt + 32'h1;
          end
        end
      end
      RSC_SEQ_GATE: begin
        // only a brown-out or power event in this cycle has already moved next_cur.seq away from here
        // wait pin release, then load the ten-cycle delay
        if (next_cur.seq == RSC_SEQ_GATE && start_gate_ok && !(pin_func && cur.pin_low)) begin
          next_cur.seq = RSC_SEQ_DELAY;
          next_cur.seq_cnt = {28'h0, START_DELAY_LOAD};
        end
      end
      RSC_SEQ_DELAY: begin
        if (next_cur.seq == RSC_SEQ_DELAY) begin
          if (cur.seq_cnt == 32'h0) begin
            next_cur.seq = RSC_SEQ_RUN;
          end else begin
            next_cur.seq_cnt = cur.seq_cnt - 32'h1;
          end
        end
      end
      RSC_SEQ_RUN: begin
        next_cur.seq_cnt = 32'h0;
      end
      default: next_cur.seq = RSC_SEQ_POWER;
    endcase
  end

  // ==========================================================
  // state register; chip reset looks like a power-on
  always_ff @(posedge mclk) begin
    if (reset) begin
      cur.seq <= RSC_SEQ_POWER;
      cur.seq_cnt <= 32'h0;
      cur.bor_cnt <= 32'h0;
      cur.pin_cnt <= 32'h0;
      cur.pin_low <= 1'b0;
      cur.flags <= FLAGS_POWERON;
      cur.ctrl <= CTRL_RESET;
      cur.rdata <= 32'h0;
      cur.slverr <= 1'b0;
      cur.apb_ready <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // outputs
  // one core reset, decoded from the registered sequence state
  assign core_reset = (cur.seq != RSC_SEQ_RUN);
  // limitation: in mode 10 the detector sleeps with the core, so the core leaves sleep first
  // hold wake until ready; no delay
  assign wake_allowed = wake_request && ((brownout_mode_select != BOR_MODE_AWAKE) || brownout_detector_ready);
  assign brownout_detector_enable = bor_active;

  assign brownout_threshold_select = brownout_level_select;

  assign ext_reset_pin_out = 1'b0;
  assign ext_reset_pin_oe = 1'b0;

  // pull-up fixed on with pin reset, software otherwise
  assign ext_pin_pullup_enable = pin_func ? 1'b1 : cur.ctrl[CTRL_PULLUP_BIT];
  assign ext_pin_gpio_in = ext_reset_pin_in;
  assign prdata = cur.rdata;
  assign pslverr = cur.slverr && pready;
  // one wait state: data and error are registered from the first access cycle
  // pready is combinational, but only from registered state and the bus inputs
  assign pready = psel && penable && cur.apb_ready;

endmodule : rsc_reset_source_controller

// File: verif/rsc_reset_source_controller_asserts.sv
// Purpose: port checks for the reset source controller
// Assumes: single mclk domain, synchronous reset
// Notes: filter bounds allow one cycle of slack for input staging
`timescale 1ns/1ps
module rsc_reset_source_controller_asserts
  import rsc_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_COUNT = 20,
  parameter int unsigned BOR_FILTER_COUNT = 4,
  parameter int unsigned PIN_FILTER_COUNT = 4
) (
  input wire logic mclk, // clock
  input wire logic reset, // chip reset
  input wire logic [1:0] brownout_mode_select, // mode
  input wire logic [1:0] brownout_level_select, // trip level
  input wire logic ext_reset_pin_enable, // pin enable
  input wire logic low_voltage_prog_enable, // lv programming
  input wire logic stack_reset_enable, // stack enable
  input wire logic supply_below_threshold, // comparator
  input wire logic brownout_detector_ready, // ready
  input wire logic ext_reset_pin_in, // pin level
  input wire logic watchdog_overflow, // pulse
  input wire logic reset_instr, // pulse
  input wire logic stack_overflow, // pulse
  input wire logic sleep_active, // sleep
  input wire logic wake_request, // wake
  input wire logic core_reset, // merged reset
  input wire logic wake_allowed, // wake gate
  input wire logic brownout_detector_enable, // detector power
  input wire logic [1:0] brownout_threshold_select, // level out
  input wire logic ext_reset_pin_oe, // pin drive
  input wire logic ext_pin_pullup_enable, // pull-up
  input wire logic ext_pin_gpio_in // pin as input
);
  logic [7:0] pin_lo;
  logic [7:0] sup_lo;
  // ==========================================================
  // saturating run lengths of a low pin and a low supply
  always_ff @(posedge mclk) begin
    pin_lo <= (reset || ext_reset_pin_in) ? 8'h00 : pin_lo + {7'h00, pin_lo != 8'hff};
    sup_lo <= (reset || !supply_below_threshold) ? 8'h00 : sup_lo + {7'h00, sup_lo != 8'hff};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_PIN_PASSIVE: assert property (!ext_reset_pin_oe) else $error("pin driven");
  AST_LEVEL: assert property (brownout_threshold_select == brownout_level_select) else $error("level");
  AST_WAKE: assert property (wake_allowed == (wake_request &&
    (brownout_mode_select != BOR_MODE_AWAKE || brownout_detector_ready))) else $error("wake gate");
  AST_ALWAYS_ON: assert property (brownout_mode_select == BOR_MODE_ALWAYS |-> brownout_detector_enable) else $error("on");
  AST_OFF: assert property (brownout_mode_select == BOR_MODE_OFF |-> !brownout_detector_enable) else $error("off");
  AST_RI: assert property (reset_instr |=> core_reset) else $error("instr reset");
  AST_WDT: assert property (watchdog_overflow && !sleep_active |=> core_reset) else $error("wdt reset");
  AST_STACK: assert property (stack_overflow && stack_reset_enable |=> core_reset) else $error("stack");
  AST_PIN_HOLD: assert property ((ext_reset_pin_enable || low_voltage_prog_enable)
    && pin_lo > PIN_FILTER_COUNT + 1 |-> core_reset) else $error("pin hold");
  AST_BOR_HOLD: assert property (brownout_mode_select == BOR_MODE_ALWAYS
    && sup_lo > BOR_FILTER_COUNT + 1 |-> core_reset) else $error("bor hold");
  AST_START_DELAY: assert property ($fell(core_reset) |-> $past(core_reset, 10)) else $error("delay");
  AST_GPIO: assert property (ext_pin_gpio_in == ext_reset_pin_in &&
    (!(ext_reset_pin_enable || low_voltage_prog_enable) || ext_pin_pullup_enable)) else $error("gpio");
endmodule : rsc_reset_source_controller_asserts

// File: verif/rsc_supply_pin_model.sv
// Purpose: supply comparator, detector warm-up and reset pin with pull-up
// Assumes: bench asks for supply droop and pin press
// Notes: ready is lost whenever the detector loses power
`timescale 1ns/1ps
module rsc_supply_pin_model #(
  parameter int unsigned WARM = 6
) (
  input wire logic mclk, // clock
  input wire logic droop, // supply sags
  input wire logic pin_low, // button pressed
  input wire logic brownout_detector_enable, // detector power
  input wire logic ext_reset_pin_oe, // device drive
  input wire logic ext_reset_pin_out, // device value
  output logic supply_below_threshold, // comparator
  output logic brownout_detector_ready, // warmed up
  output logic ext_reset_pin_in // resolved pin
);
  logic [3:0] warm = 4'h0;
  assign ext_reset_pin_in = ext_reset_pin_oe ? ext_reset_pin_out : !pin_low;
  assign supply_below_threshold = droop;
  always @(posedge mclk) begin
    warm <= !brownout_detector_enable ? 4'h0 : warm + {3'h0, warm != 4'(WARM)};
  end
  assign brownout_detector_ready = brownout_detector_enable && warm == 4'(WARM);
endmodule : rsc_supply_pin_model

// File: verif/rsc_reset_source_controller_tb.sv
// Purpose: self-checking bench for the reset source controller
// Assumes: short power-up timer and filters for run time
// Notes: apb master samples pready at the rising edge that completes a transfer
`timescale 1ns/1ps
module rsc_reset_source_controller_tb;
  import rsc_pkg::*;
  localparam int PW = 20;
  localparam int FC = 4;
  logic mclk, reset, ext_reset_pin_enable, low_voltage_prog_enable, powerup_timer_enable, stack_reset_enable;
  logic poweron_detect, supply_below_threshold, brownout_detector_ready, prog_mode_exit, ext_reset_pin_in;
  logic watchdog_overflow, reset_instr, stack_overflow, stack_underflow, sleep_active, wake_request;
  logic psel, penable, pwrite, pready, pslverr, core_reset, wake_allowed, brownout_detector_enable;
  logic ext_reset_pin_out, ext_reset_pin_oe, ext_pin_pullup_enable, ext_pin_gpio_in, droop, pin_low, err, e;
  logic [1:0] brownout_mode_select, brownout_level_select, brownout_threshold_select;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r, seed = 32'h3a;
  int fail_count = 0, check_count = 0, cyc = 0, n;
  rsc_reset_source_controller #(.POWERUP_TIMER_COUNT(PW), .BOR_FILTER_COUNT(FC), .PIN_FILTER_COUNT(FC))
    i_rsc_reset_source_controller (.*);
  rsc_supply_pin_model i_rsc_supply_pin_model (.*);
  // ==========================================================
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // expected flags after each event kind, wdt compares bits 4 to 6 only
  function automatic logic [31:0] fexp(input int w, input logic en);
    case (w)
      0: return 32'h7b;
      1: return en ? 32'h10 : 32'h20;
      2: return en ? 32'h17f : 32'h7f;
      3: return en ? 32'hff : 32'h7f;
      default: return {23'h0, FLAGS_POWERON};
    endcase
  endfunction : fexp
  function automatic logic exp_det(input logic [1:0] m, input logic s, input logic sb);
    case (m)
      BOR_MODE_ALWAYS: return 1'b1;
      BOR_MODE_AWAKE: return !s;
      BOR_MODE_SOFT: return sb;
      default: return 1'b0;
    endcase
  endfunction : exp_det
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic hit(input int w);
    @(posedge mclk);
    {reset_instr, watchdog_overflow, stack_overflow, stack_underflow, prog_mode_exit} <= 5'h10 >> w;
    @(posedge mclk);
    {reset_instr, watchdog_overflow, stack_overflow, stack_underflow, prog_mode_exit} <= 5'h00;
  endtask : hit
  // counts cycles spent in core reset
  task automatic run_wait(output int hi);
    hi = 0;
    @(negedge mclk);
    while (core_reset === 1'b1 && hi < 3000) begin
      hi++;
      @(negedge mclk);
    end
    if (hi >= 3000) fail_count++;
  endtask : run_wait
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    {brownout_mode_select, brownout_level_select} = 4'hc;
    {ext_reset_pin_enable, low_voltage_prog_enable, stack_reset_enable, poweron_detect} = 4'h0;
    powerup_timer_enable = 1'b1;
    {prog_mode_exit, watchdog_overflow, reset_instr, stack_overflow, stack_underflow} = 5'h00;
    {sleep_active, wake_request, droop, pin_low, psel, penable, pwrite} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    run_wait(n);
    apb(1'b0, FLAGS_OFFSET, 32'h0);
    chk(rd, {23'h0, FLAGS_POWERON});
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd, {30'h0, CTRL_RESET});
    apb(1'b0, 8'h0c, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("power-on test done");
    for (int i = 0; i < 10; i++) begin
      stack_reset_enable <= (i >= 5);
      sleep_active <= (i == 6);
      apb(1'b1, FLAGS_OFFSET, 32'h7f);
      hit(i % 5);
      run_wait(n);
      chk({31'h0, n > 0}, {31'h0, !(i == 2 || i == 3 || i == 6)});
      if (i % 5 == 0) chk(n, START_DELAY_CYCLES + 1);
      apb(1'b0, FLAGS_OFFSET, 32'h0);
      chk(rd & ((i % 5 == 1) ? 32'h70 : 32'h1ff), fexp(i % 5, i >= 5));
    end
    $display("cause test done");
    for (int c = 0; c < 4; c++) begin
      {ext_reset_pin_enable, low_voltage_prog_enable} <= c[1:0];
      apb(1'b1, FLAGS_OFFSET, 32'h7f);
      pin_low <= 1'b1;
      repeat (FC - 2) @(posedge mclk);
      pin_low <= 1'b0;
      repeat (8) @(negedge mclk);
      chk({31'h0, core_reset}, 32'h0);
      @(posedge mclk);
      pin_low <= 1'b1;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      chk({29'h0, ext_reset_pin_out, core_reset, ext_pin_gpio_in}, {29'h0, 1'b0, c != 0, 1'b0});
      @(posedge mclk);
      pin_low <= 1'b0;
      run_wait(n);
      if (c != 0) chk({31'h0, n >= 10}, 32'h1);
      apb(1'b0, FLAGS_OFFSET, 32'h0);
      chk(rd, (c != 0) ? 32'h77 : 32'h7f);
    end
    $display("pin test done");
    {ext_reset_pin_enable, low_voltage_prog_enable} <= 2'h0;
    for (int m = 0; m < 4; m++) begin
      r = rnd();
      @(posedge mclk);
      brownout_mode_select <= m[1:0];
      brownout_level_select <= r[5:4];
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      run_wait(n);
      apb(1'b1, CTRL_OFFSET, {30'h0, r[1:0]});
      @(posedge mclk);
      chk({31'h0, ext_pin_pullup_enable}, {31'h0, r[1]});
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd & 32'h3, {31'h0, brownout_detector_ready});
      for (int s = 0; s < 2; s++) begin
        sleep_active <= s[0] ^ r[2];
        wake_request <= r[3];
        repeat (3) @(negedge mclk);
        chk({31'h0, brownout_detector_enable}, {31'h0, exp_det(m[1:0], s[0] ^ r[2], r[0])});
        @(posedge mclk);
      end
      sleep_active <= 1'b0;
      repeat (10) @(posedge mclk);
      droop <= 1'b1;
      repeat (FC - 2) @(posedge mclk);
      droop <= 1'b0;
      repeat (8) @(negedge mclk);
      chk({31'h0, core_reset}, 32'h0);
      @(posedge mclk);
      droop <= 1'b1;
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      e = (m >= 2) || (m == 1 && r[0]);
      chk({31'h0, core_reset}, {31'h0, e});
      @(posedge mclk);
      droop <= 1'b0;
      run_wait(n);
      if (e) chk({31'h0, n >= PW + 10}, 32'h1);
      apb(1'b0, FLAGS_OFFSET, 32'h0);
      chk(rd, e ? 32'h7c : 32'h7d);
    end
    $display("brown-out test done");
    finish_test();
  end
endmodule : rsc_reset_source_controller_tb
bind rsc_reset_source_controller rsc_reset_source_controller_asserts #(.POWERUP_TIMER_COUNT(POWERUP_TIMER_COUNT),
  .BOR_FILTER_COUNT(BOR_FILTER_COUNT), .PIN_FILTER_COUNT(PIN_FILTER_COUNT)) i_rsc_asserts (.*);
